// ---- hdl/cfm_feature_control.sv ----
// Feature and mode control: serial register port, mode selection and sample ordering
`timescale 1ns/1ns
module cfm_feature_control
  import cfm_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 12
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  // Serial register port, clocked by the host
  input  wire logic                    i_sclk,
  input  wire logic                    i_scs_n,
  input  wire logic                    i_sdi,
  output logic                         o_sdo,
  output logic                         o_sdo_oe_n,
  // Dedicated control pins
  input  wire logic                    i_register_control_select,
  input  wire logic                    i_dual_edge_pin,
  input  wire logic                    i_test_pattern_select,
  input  wire logic                    i_i_channel_sleep,
  input  wire logic                    i_q_channel_sleep,
  input  wire logic                    i_input_range_setting,
  input  wire logic                    i_output_clock_phase_pin,
  input  wire logic                    i_calibrate_pin,
  input  wire logic                    i_demux_bypass_select,
  input  wire logic                    i_trigger,
  // Converter core samples, one per channel per clock
  input  wire logic [SAMPLE_WIDTH-1:0] i_i_sample,
  input  wire logic [SAMPLE_WIDTH-1:0] i_q_sample,
  // Feature controls towards the analog core
  output logic                         o_extended_control_mode,
  output logic                         o_dual_edge_sampling,
  output logic                         o_alternate_input_select,
  output logic                         o_two_input_interleave,
  output logic                         o_background_phase_adjust,
  output logic                         o_twos_complement_select,
  output logic                         o_test_pattern_select,
  output logic                         o_i_channel_sleep,
  output logic                         o_q_channel_sleep,
  output logic                         o_calibrate_request,
  output logic                         o_output_clock_phase_select,
  output logic                         o_output_swing_select,
  output logic                         o_trigger_stamp_enable,
  output logic                         o_expose_trim_values,
  output logic [14:0]                  o_range_i,
  output logic [14:0]                  o_range_q,
  output logic [12:0]                  o_offset_i,
  output logic [12:0]                  o_offset_q,
  output logic [6:0]                   o_skew_trim,
  output logic                         o_sample_delay_enable,
  output logic [15:0]                  o_sample_delay_coarse,
  output logic [15:0]                  o_sample_delay_fine,
  output logic [15:0]                  o_calibration_adjust,
  output logic [15:0]                  o_multi_chip_sync,
  // Output buses
  output logic [SAMPLE_WIDTH-1:0]      o_q_channel_delayed_bus,
  output logic [SAMPLE_WIDTH-1:0]      o_i_channel_delayed_bus,
  output logic [SAMPLE_WIDTH-1:0]      o_q_channel_primary_bus,
  output logic [SAMPLE_WIDTH-1:0]      o_i_channel_primary_bus,
  output logic                         o_word_valid
);

  if (SAMPLE_WIDTH < 8 || SAMPLE_WIDTH > 16) begin : g_width_check
    $error("SAMPLE_WIDTH must lie between 8 and 16");
  end

  localparam int SW = SAMPLE_WIDTH;

  // ------------------------------------------------------------------
  // Serial domain. The host clock stands still between frames, so the
  // bit counter is cleared by chip select itself, not by a later edge.
  // ------------------------------------------------------------------
  logic [4:0]  bit_count;
  logic [7:0]  cmd_shift;
  logic [14:0] data_shift;
  logic [14:0] out_shift;
  logic [3:0]  wr_addr;
  logic [15:0] wr_data;
  logic        wr_toggle;

  wire         cmd_read   = cmd_shift[7];
  wire         cmd_valid  = (cmd_shift[6:5] == CFM_CMD_FIXED);
  wire  [3:0]  cmd_addr   = cmd_shift[4:1];
  wire         in_cmd     = (bit_count < CFM_CNT_CMD);
  wire         last_edge  = (bit_count == CFM_CNT_LAST);
  wire         do_write   = last_edge && cmd_valid && !cmd_read;

  // Reset clears it too: chip select may idle high from power-up and give no edge
  always_ff @(posedge i_sclk or posedge i_scs_n or posedge i_reset) begin
    if (i_scs_n || i_reset) begin
      bit_count <= 5'd0;
    end else if (bit_count != CFM_CNT_DONE) begin
      bit_count <= bit_count + 5'd1;
    end
  end

  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      cmd_shift  <= 8'h00;
      data_shift <= 15'h0000;
    end else if (in_cmd) begin
      cmd_shift  <= {cmd_shift[6:0], i_sdi};
    end else if (bit_count != CFM_CNT_DONE) begin
      data_shift <= {data_shift[13:0], i_sdi};
    end
  end

  // Held words stay stable until the next complete write frame,
  // which is far longer than the three-stage toggle crossing below.
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      wr_addr   <= 4'h0;
      wr_data   <= 16'h0000;
      wr_toggle <= 1'b0;
    end else if (do_write) begin
      wr_addr   <= cmd_addr;
      wr_data   <= {data_shift, i_sdi};
      wr_toggle <= ~wr_toggle;
    end
  end

  // Read word: unmapped addresses read zero. The register file only
  // changes on a completed write or a mode reset, never mid-frame.
  logic [15:0] regs [16];
  wire  [15:0] rd_word = CFM_ADDR_MAP[cmd_addr] ? regs[cmd_addr] : 16'h0000;
  wire         rd_go   = (bit_count == CFM_CNT_CMD) && cmd_read && cmd_valid;
  wire         rd_more = (bit_count > CFM_CNT_CMD) && (bit_count < CFM_CNT_DONE);

  // The driver stays released through reset as well
  always_ff @(negedge i_sclk or posedge i_scs_n or posedge i_reset) begin
    if (i_scs_n || i_reset) begin
      o_sdo      <= 1'b0;
      o_sdo_oe_n <= 1'b1;
      out_shift  <= 15'h0000;
    end else if (rd_go) begin
      o_sdo      <= rd_word[15];
      o_sdo_oe_n <= 1'b0;
      out_shift  <= rd_word[14:0];
    end else if (rd_more) begin
      o_sdo      <= out_shift[14];
      out_shift  <= {out_shift[13:0], 1'b0};
    end
  end

  // ------------------------------------------------------------------
  // Main domain: synchronise pins and the write toggle
  // ------------------------------------------------------------------
  localparam int NPIN = 10;
  wire  [NPIN-1:0] pin_raw = {i_trigger, i_demux_bypass_select, i_calibrate_pin,
                              i_output_clock_phase_pin, i_input_range_setting,
                              i_q_channel_sleep, i_i_channel_sleep,
                              i_test_pattern_select, i_dual_edge_pin,
                              i_register_control_select};
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [2:0]      wr_sync;
  logic            cal_pin_last;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_meta     <= '0;
      pin_sync     <= '0;
      wr_sync      <= 3'b000;
      cal_pin_last <= 1'b0;
    end else begin
      pin_meta     <= pin_raw;
      pin_sync     <= pin_meta;
      wr_sync      <= {wr_sync[1:0], wr_toggle};
      cal_pin_last <= pin_sync[7];
    end
  end

  wire pin_mode    = pin_sync[0];
  wire ext_mode    = !pin_mode;
  // Held address and data are read only after the toggle has crossed
  wire wr_event    = wr_sync[2] ^ wr_sync[1];
  wire reg_write   = wr_event && ext_mode;
  wire recal_write = reg_write && (wr_addr == CFM_ADDR_MAIN) && wr_data[CFM_BIT_RECAL];
  wire cal_pin_hit = pin_mode && pin_sync[7] && !cal_pin_last;

  // Register file; the recalibrate bit never stores, so it reads zero
  for (genvar a = 0; a < 16; a++) begin : g_regs
    localparam logic [3:0]  ADDR    = 4'(a);
    localparam logic [15:0] RST_VAL = cfm_default(ADDR);
    wire [15:0] wr_mask = (ADDR == CFM_ADDR_MAIN) ? 16'h7FFF : 16'hFFFF;
    always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
        regs[a] <= RST_VAL;
      end else if (pin_mode || !CFM_ADDR_MAP[a]) begin
        regs[a] <= RST_VAL;
      end else if (reg_write && wr_addr == ADDR) begin
        regs[a] <= wr_data & wr_mask;
      end
    end
  end

  // ------------------------------------------------------------------
  // Feature selection
  // ------------------------------------------------------------------
  wire [15:0] main_cfg    = regs[CFM_ADDR_MAIN];
  wire        next_dual   = ext_mode ? main_cfg[CFM_BIT_DUAL_EDGE] : pin_sync[1];
  wire        next_alt    = ext_mode && main_cfg[CFM_BIT_ALT_INPUT]
                            && next_dual;
  wire        next_both   = ext_mode && main_cfg[CFM_BIT_BOTH_IN] && next_dual;
  wire        next_twos   = ext_mode && main_cfg[CFM_BIT_TWOS];
  wire        next_pat    = ext_mode ? main_cfg[CFM_BIT_PATTERN] : pin_sync[2];
  // Either the pin or the bit sleeps a channel while in extended mode
  wire        next_i_slp  = pin_sync[3] || (ext_mode && main_cfg[CFM_BIT_I_SLEEP]);
  wire        next_q_slp  = pin_sync[4] || (ext_mode && main_cfg[CFM_BIT_Q_SLEEP]);
  wire        next_phase  = ext_mode ? main_cfg[CFM_BIT_PHASE] : pin_sync[6];
  wire        next_swing  = ext_mode ? main_cfg[CFM_BIT_SWING] : 1'b1;
  wire        next_stamp  = ext_mode && main_cfg[CFM_BIT_STAMP];
  wire        next_expose = ext_mode && regs[CFM_ADDR_CAL_ADJ][CFM_BIT_EXPOSE];
  wire [14:0] pin_range   = pin_sync[5] ? CFM_RST_RANGE[14:0] : CFM_RANGE_MIN;
  wire [14:0] next_rng_i  = ext_mode ? regs[CFM_ADDR_RANGE_I][14:0] : pin_range;
  wire [14:0] next_rng_q  = ext_mode ? regs[CFM_ADDR_RANGE_Q][14:0] : pin_range;
  // Registers hold defaults in pin mode, so these fall back on their own
  wire [12:0] next_ofs_i  = regs[CFM_ADDR_OFFSET_I][12:0];
  wire [12:0] next_ofs_q  = regs[CFM_ADDR_OFFSET_Q][12:0];
  wire [6:0]  next_skew   = regs[CFM_ADDR_SKEW][6:0];
  wire        next_dly_en = regs[CFM_ADDR_DELAY_CRS][CFM_BIT_DELAY_EN];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_extended_control_mode     <= 1'b0;
      o_dual_edge_sampling        <= 1'b0;
      o_alternate_input_select    <= 1'b0;
      o_two_input_interleave      <= 1'b0;
      o_background_phase_adjust   <= 1'b0;
      o_twos_complement_select    <= 1'b0;
      o_test_pattern_select       <= 1'b0;
      o_i_channel_sleep           <= 1'b0;
      o_q_channel_sleep           <= 1'b0;
      o_calibrate_request         <= 1'b0;
      o_output_clock_phase_select <= 1'b0;
      o_output_swing_select       <= CFM_RST_MAIN[CFM_BIT_SWING];
      o_trigger_stamp_enable      <= 1'b0;
      o_expose_trim_values        <= 1'b0;
      o_range_i                   <= CFM_RST_RANGE[14:0];
      o_range_q                   <= CFM_RST_RANGE[14:0];
      o_offset_i                  <= 13'h0000;
      o_offset_q                  <= 13'h0000;
      o_skew_trim                 <= CFM_RST_SKEW[6:0];
      o_sample_delay_enable       <= 1'b0;
      o_sample_delay_coarse       <= CFM_RST_ZERO;
      o_sample_delay_fine         <= CFM_RST_ZERO;
      o_calibration_adjust        <= CFM_RST_ZERO;
      o_multi_chip_sync           <= CFM_RST_ZERO;
    end else begin
      o_extended_control_mode     <= ext_mode;
      o_dual_edge_sampling        <= next_dual;
      o_alternate_input_select    <= next_alt;
      o_two_input_interleave      <= next_both;
      o_background_phase_adjust   <= next_dual;
      o_twos_complement_select    <= next_twos;
      o_test_pattern_select       <= next_pat;
      o_i_channel_sleep           <= next_i_slp;
      o_q_channel_sleep           <= next_q_slp;
      o_calibrate_request         <= recal_write || cal_pin_hit;
      o_output_clock_phase_select <= next_phase;
      o_output_swing_select       <= next_swing;
      o_trigger_stamp_enable      <= next_stamp;
      o_expose_trim_values        <= next_expose;
      o_range_i                   <= next_rng_i;
      o_range_q                   <= next_rng_q;
      o_offset_i                  <= next_ofs_i;
      o_offset_q                  <= next_ofs_q;
      o_skew_trim                 <= next_skew;
      o_sample_delay_enable       <= next_dly_en;
      o_sample_delay_coarse       <= regs[CFM_ADDR_DELAY_CRS];
      o_sample_delay_fine         <= regs[CFM_ADDR_DELAY_FINE];
      o_calibration_adjust        <= regs[CFM_ADDR_CAL_ADJ];
      o_multi_chip_sync           <= regs[CFM_ADDR_SYNC];
    end
  end

  // ------------------------------------------------------------------
  // Sample ordering. Per clock the core gives one Q word, sampled on
  // the falling sample edge, and one I word on the rising edge; Q is
  // the earlier of the pair when interleaving.
  // ------------------------------------------------------------------
  wire          demux   = !pin_sync[8];
  wire [SW-1:0] fmt_msb = {next_twos, {(SW-1){1'b0}}};
  // With the stamp on, the sample LSB gives way to the trigger, leaving one bit less
  wire [SW-1:0] lsb_mask = SW'(next_stamp);
  wire [SW-1:0] lsb_trig = SW'(next_stamp && pin_sync[9]);

  cfm_lane_type lane;
  logic         pat_phase;
  logic [SW-1:0] hold_q;
  logic [SW-1:0] hold_i;

  // Interleaved and plain modes share one path; the input choice and
  // edge assignment are made in the analog core from the outputs above
  wire [SW-1:0] pat_inv = {SW{pat_phase}};
  // Two's complement is offset binary with the top bit inverted
  wire [SW-1:0] q_conv  = ((i_q_sample ^ fmt_msb) & ~lsb_mask) | lsb_trig;
  wire [SW-1:0] i_conv  = ((i_i_sample ^ fmt_msb) & ~lsb_mask) | lsb_trig;
  wire [SW-1:0] q_word  = next_pat ? (SW'(CFM_PAT_Q) ^ pat_inv) : q_conv;
  wire [SW-1:0] i_word  = next_pat ? (SW'(CFM_PAT_I) ^ pat_inv) : i_conv;
  wire [SW-1:0] qd_pat  = SW'(CFM_PAT_QD) ^ pat_inv;
  wire [SW-1:0] id_pat  = SW'(CFM_PAT_ID) ^ pat_inv;
  wire          emit    = !demux || (lane == CFM_LANE_PRIMARY);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      lane      <= CFM_LANE_DELAYED;
      pat_phase <= 1'b0;
      hold_q    <= '0;
      hold_i    <= '0;
    end else begin
      case (lane)
        CFM_LANE_DELAYED: lane <= demux ? CFM_LANE_PRIMARY : CFM_LANE_DELAYED;
        CFM_LANE_PRIMARY: lane <= CFM_LANE_DELAYED;
        default:          lane <= CFM_LANE_DELAYED;
      endcase
      if (emit) begin
        pat_phase <= ~pat_phase;
      end
      if (lane == CFM_LANE_DELAYED) begin
        hold_q <= q_word;
        hold_i <= i_word;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_q_channel_delayed_bus <= '0;
      o_i_channel_delayed_bus <= '0;
      o_q_channel_primary_bus <= '0;
      o_i_channel_primary_bus <= '0;
      o_word_valid            <= 1'b0;
    end else begin
      o_word_valid <= emit;
      if (emit) begin
        o_q_channel_delayed_bus <= next_pat ? qd_pat : hold_q;
        o_i_channel_delayed_bus <= next_pat ? id_pat : hold_i;
        o_q_channel_primary_bus <= next_q_slp ? '0 : q_word;
        o_i_channel_primary_bus <= next_i_slp ? '0 : i_word;
      end
    end
  end

endmodule : cfm_feature_control

// ---- hdl/cfm_pkg.sv ----
// Constants shared by the converter feature and mode control block
package cfm_pkg;

  // Serial frame layout
  localparam int           CFM_FRAME_BITS  = 24;
  localparam int           CFM_CMD_BITS    = 8;
  localparam logic [1:0]   CFM_CMD_FIXED   = 2'b10;
  localparam logic [4:0]   CFM_CNT_CMD     = 5'd8;
  localparam logic [4:0]   CFM_CNT_LAST    = 5'd23;
  localparam logic [4:0]   CFM_CNT_DONE    = 5'd24;

  // Register addresses
  localparam logic [3:0]   CFM_ADDR_MAIN       = 4'h0;
  localparam logic [3:0]   CFM_ADDR_OFFSET_I   = 4'h2;
  localparam logic [3:0]   CFM_ADDR_RANGE_I    = 4'h3;
  localparam logic [3:0]   CFM_ADDR_CAL_ADJ    = 4'h4;
  localparam logic [3:0]   CFM_ADDR_SKEW       = 4'h7;
  localparam logic [3:0]   CFM_ADDR_OFFSET_Q   = 4'hA;
  localparam logic [3:0]   CFM_ADDR_RANGE_Q    = 4'hB;
  localparam logic [3:0]   CFM_ADDR_DELAY_CRS  = 4'hC;
  localparam logic [3:0]   CFM_ADDR_DELAY_FINE = 4'hD;
  localparam logic [3:0]   CFM_ADDR_SYNC       = 4'hE;

  // Implemented addresses, one bit per address
  localparam logic [15:0]  CFM_ADDR_MAP = 16'h7C9D;

  // Fields of main_configuration
  localparam int           CFM_BIT_RECAL      = 15;
  localparam int           CFM_BIT_PHASE      = 14;
  localparam int           CFM_BIT_SWING      = 13;
  localparam int           CFM_BIT_PATTERN    = 12;
  localparam int           CFM_BIT_I_SLEEP    = 11;
  localparam int           CFM_BIT_Q_SLEEP    = 10;
  localparam int           CFM_BIT_DUAL_EDGE  = 7;
  localparam int           CFM_BIT_ALT_INPUT  = 6;
  localparam int           CFM_BIT_BOTH_IN    = 5;
  localparam int           CFM_BIT_TWOS       = 4;
  localparam int           CFM_BIT_STAMP      = 3;
  // Field of calibration_adjust
  localparam int           CFM_BIT_EXPOSE     = 7;
  // Offset trim: sign above a 12-bit magnitude
  localparam int           CFM_BIT_OFS_SIGN   = 12;
  // Sample clock delay enable in the coarse register
  localparam int           CFM_BIT_DELAY_EN   = 0;

  // Values after reset
  localparam logic [15:0]  CFM_RST_MAIN   = 16'h2000;
  localparam logic [15:0]  CFM_RST_RANGE  = 16'h4000;
  localparam logic [15:0]  CFM_RST_SKEW   = 16'h0040;
  localparam logic [15:0]  CFM_RST_ZERO   = 16'h0000;
  localparam logic [14:0]  CFM_RANGE_MIN  = 15'h0000;

  // Longest sampling clock delay in picoseconds
  localparam int           CFM_DELAY_MAX_PS = 825;

  // Test pattern words per bus, inverted on alternate words
  localparam logic [11:0]  CFM_PAT_QD = 12'h000;
  localparam logic [11:0]  CFM_PAT_ID = 12'h004;
  localparam logic [11:0]  CFM_PAT_Q  = 12'h008;
  localparam logic [11:0]  CFM_PAT_I  = 12'h010;

  typedef enum logic {
    CFM_LANE_DELAYED = 1'b0,
    CFM_LANE_PRIMARY = 1'b1
  } cfm_lane_type;

  function automatic logic [15:0] cfm_default(input logic [3:0] addr);
    case (addr)
      CFM_ADDR_MAIN:                   cfm_default = CFM_RST_MAIN;
      CFM_ADDR_RANGE_I, CFM_ADDR_RANGE_Q: cfm_default = CFM_RST_RANGE;
      CFM_ADDR_SKEW:                   cfm_default = CFM_RST_SKEW;
      default:                         cfm_default = CFM_RST_ZERO;
    endcase
  endfunction : cfm_default

endpackage : cfm_pkg

// ---- tb/cfm_feature_control_tb.sv ----
// Self-checking bench for the feature and mode control block
`timescale 1ns/1ns
module cfm_feature_control_tb;
  logic i_clk = 0, i_reset = 0, i_register_control_select = 0, i_dual_edge_pin = 0;
  logic i_test_pattern_select = 0, i_i_channel_sleep = 0, i_q_channel_sleep = 0;
  logic i_input_range_setting = 0, i_output_clock_phase_pin = 0, i_calibrate_pin = 0;
  logic i_demux_bypass_select = 0, i_trigger = 0;
  logic [11:0] i_i_sample = 0, i_q_sample = 12'h100;
  wire i_sclk, i_scs_n, i_sdi, o_sdo, o_sdo_oe_n, o_extended_control_mode, o_word_valid;
  wire o_dual_edge_sampling, o_alternate_input_select, o_two_input_interleave;
  wire o_twos_complement_select, o_test_pattern_select, o_i_channel_sleep;
  wire o_output_clock_phase_select, o_q_channel_sleep, o_calibrate_request, o_expose_trim_values;
  wire [14:0] o_range_i;
  wire [6:0]  o_skew_trim;
  wire [11:0] o_q_channel_delayed_bus, o_i_channel_delayed_bus;
  wire [11:0] o_q_channel_primary_bus, o_i_channel_primary_bus;
  int bad_count = 0, checks = 0, cycles = 0, cal_count = 0;
  logic [15:0] rdat;
  cfm_host_model host_u (.o_sclk(i_sclk), .o_scs_n(i_scs_n), .o_sdi(i_sdi), .i_sdo(o_sdo),
    .i_sdo_oe_n(o_sdo_oe_n));
  cfm_feature_control dut_u (.*, .o_background_phase_adjust(), .o_output_swing_select(),
    .o_trigger_stamp_enable(), .o_range_q(), .o_offset_i(),
    .o_offset_q(), .o_sample_delay_enable(), .o_sample_delay_coarse(),
    .o_sample_delay_fine(), .o_calibration_adjust(), .o_multi_chip_sync());
  initial forever #5 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    i_i_sample <= i_i_sample + 12'h001;
    i_q_sample <= i_q_sample + 12'h001;
    if (o_calibrate_request === 1'b1) cal_count++;
  end
  always @(posedge i_clk) if (++cycles > 30000) begin
    bad_count++;
    conclude();
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chb
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host_u.xfer(1'b0, a, d, rdat);
    repeat (8) @(negedge i_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    host_u.xfer(1'b1, a, 16'hFFFF, rdat);
    chk(rdat, exp);
    @(negedge i_clk);
  endtask : rd
  task automatic conclude;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    // A real rising edge reaches the serial-side flops, whose clock is idle now
    #1 i_reset = 1;
    repeat (5) @(negedge i_clk);
    i_reset = 0;
    // Unmapped addresses read zero as well
    for (int a = 0; a < 16; a++) rd(a[3:0], a == 0 ? 16'h2000 : (a == 3 || a == 11) ?
      16'h4000 : a == 7 ? 16'h0040 : 16'h0000);
    $display("test defaults done");
    wr(4'h0, 16'h20D0);
    chb(o_alternate_input_select, 1);
    chb(o_twos_complement_select, 1);
    wr(4'h1, 16'h1234);
    rd(4'h1, 16'h0000);
    wr(4'h0, 16'h20A0);
    chb(o_two_input_interleave, 1);
    wr(4'h3, 16'h1234);
    chk({1'b0, o_range_i}, 16'h1234);
    wr(4'h0, 16'hA0A0);
    rd(4'h0, 16'h20A0);
    chk(16'(cal_count), 16'h0001);
    wr(4'h7, 16'h007F);
    chk({9'h000, o_skew_trim}, 16'h007F);
    $display("test registers done");
    if (o_word_valid !== 1'b1) @(negedge i_clk);
    chk({4'h0, o_i_channel_primary_bus - o_i_channel_delayed_bus}, 16'h0001);
    chk({4'h0, o_i_channel_delayed_bus - o_q_channel_delayed_bus}, 16'h0F00);
    @(negedge i_clk);
    chb(o_word_valid, 0);
    i_demux_bypass_select = 1;
    repeat (6) @(negedge i_clk);
    rdat = {4'h0, o_i_channel_primary_bus};
    @(negedge i_clk);
    chk({4'h0, o_i_channel_primary_bus} - rdat, 16'h0001);
    chk({4'h0, o_q_channel_primary_bus - o_i_channel_primary_bus}, 16'h0100);
    chb(o_word_valid, 1);
    $display("test sample order done");
    i_trigger = 1;
    wr(4'h0, 16'h6408);
    chb(o_output_clock_phase_select, 1);
    chb(o_q_channel_sleep, 1);
    chk({4'h0, o_q_channel_primary_bus}, 16'h0000);
    chb(o_i_channel_primary_bus[0], 1);
    i_trigger = 0;
    wr(4'h4, 16'h0080);
    chb(o_expose_trim_values, 1);
    chb(o_i_channel_primary_bus[0], 0);
    $display("test output controls done");
    i_register_control_select = 1;
    i_dual_edge_pin = 1;
    i_test_pattern_select = 1;
    i_input_range_setting = 1;
    i_calibrate_pin = 1;
    repeat (6) @(negedge i_clk);
    chb(o_extended_control_mode, 0);
    chb(o_dual_edge_sampling, 1);
    chk({9'h000, o_skew_trim}, 16'h0040);
    chk({1'b0, o_range_i}, 16'h4000);
    chb(o_test_pattern_select, 1);
    chk({4'h0, o_i_channel_primary_bus ^ o_q_channel_primary_bus}, 16'h0018);
    chk(16'(cal_count), 16'h0002);
    chb(o_expose_trim_values, 0);
    i_dual_edge_pin = 0;
    i_i_channel_sleep = 1;
    i_input_range_setting = 0;
    repeat (6) @(negedge i_clk);
    chb(o_i_channel_sleep, 1);
    chk({4'h0, o_i_channel_primary_bus}, 16'h0000);
    chk({1'b0, o_range_i}, 16'h0000);
    i_register_control_select = 0;
    i_i_channel_sleep = 0;
    repeat (6) @(negedge i_clk);
    rd(4'h7, 16'h0040);
    $display("test pin mode done");
    conclude();
  end
endmodule : cfm_feature_control_tb
bind cfm_feature_control cfm_monitor mon_u (.*);

// ---- tb/cfm_host_model.sv ----
// Serial host model: 24-bit frames, clock held low between frames
`timescale 1ns/1ns
module cfm_host_model (
  output logic     o_sclk, o_scs_n, o_sdi,
  input wire logic i_sdo, i_sdo_oe_n
);
  // Data input idles high as its pull-up would leave it
  initial begin
    o_sclk = 0;
    o_scs_n = 1;
    o_sdi = 1;
  end
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    logic [23:0] f;
    f = {rd, 2'b10, a, 1'b0, d};
    q = 16'h0000;
    #3 o_scs_n = 0;
    for (int k = 23; k >= 0; k--) begin
      o_sdi = f[k];
      #80 o_sclk = 1;
      // A released line reads back inverted so a missing driver shows
      if (k < 16) q[k] = i_sdo_oe_n ? ~i_sdo : i_sdo;
      #80 o_sclk = 0;
    end
    #80 o_scs_n = 1;
    o_sdi = 1;
    #80;
  endtask : xfer
endmodule : cfm_host_model

// ---- tb/cfm_monitor.sv ----
// Assertion checker watching the top-level ports of the feature control block
`timescale 1ns/1ns
module cfm_monitor (
  input wire logic        i_clk, i_reset, i_scs_n, o_sdo_oe_n,
  input wire logic        o_extended_control_mode, o_dual_edge_sampling,
  input wire logic        o_background_phase_adjust, o_alternate_input_select,
  input wire logic        o_two_input_interleave, o_twos_complement_select,
  input wire logic        o_trigger_stamp_enable, o_output_swing_select,
  input wire logic        o_calibrate_request, o_sample_delay_enable,
  input wire logic [14:0] o_range_i, o_range_q,
  input wire logic [12:0] o_offset_i, o_offset_q,
  input wire logic [6:0]  o_skew_trim
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Four cycles of pin mode let the forced defaults settle first
  sequence pin_mode; !o_extended_control_mode [*4]; endsequence
  a_adjust_tracks_dual: assert property (
    o_background_phase_adjust == o_dual_edge_sampling) else $error("phase adjust wrong");
  a_input_needs_dual: assert property (
    o_alternate_input_select || o_two_input_interleave |-> o_dual_edge_sampling)
    else $error("input choice without dual edge");
  a_pin_single_input: assert property (
    pin_mode |-> !o_alternate_input_select && !o_two_input_interleave)
    else $error("pin mode input choice");
  a_pin_format_fixed: assert property (
    pin_mode |-> !o_twos_complement_select && o_output_swing_select && !o_trigger_stamp_enable)
    else $error("pin mode format");
  a_pin_range_levels: assert property (
    pin_mode |-> (o_range_i == 15'h4000 || o_range_i == 15'h0000) && o_range_q == o_range_i)
    else $error("pin mode range");
  a_pin_trims_default: assert property (
    pin_mode |-> o_offset_i == 0 && o_offset_q == 0 && !o_sample_delay_enable
    && o_skew_trim == 7'h40) else $error("pin mode trims");
  a_cal_one_pulse: assert property (
    $rose(o_calibrate_request) |=> !o_calibrate_request) else $error("calibrate pulse long");
  a_sdo_released: assert property (
    i_scs_n [*2] |-> o_sdo_oe_n) else $error("serial out driven while deselected");
endmodule : cfm_monitor
